/* File: core/address_gen_stack_check.sv */
// effective-address generator with software stack checks and ram gating
// assumes the decoder holds its request one cycle and the register file
// supplies pointer and base operand values in that same cycle
`timescale 1ns/1ps
`default_nettype none
module address_gen_stack_check
  import agu_pkg::*;
#(
  parameter int unsigned DATA_W = 16
)
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // decoded instruction
  input wire logic req_i,
  input wire addr_mode_t mode_i,
  input wire logic is_move_i,
  input wire logic is_mul_i,
  input wire logic dest_is_default_working_reg_i,
  input wire logic [FILE_ADDR_W-1:0] file_addr_i,
  input wire logic [ADDR_W-1:0] move_addr_i,
  input wire logic [REG_IDX_W-1:0] ptr_idx_i,
  input wire logic [ADDR_W-1:0] ptr_val_i,
  input wire logic [ADDR_W-1:0] base_val_i,
  input wire logic [LONG_LIT_W-1:0] literal_i,
  input wire logic long_literal_i,
  input wire logic signed [ADDR_W-1:0] modifier_i,
  // stack operations
  input wire stack_op_t stack_op_i,
  input wire logic [22:0] pc_i,
  input wire logic [7:0] status_low_byte_i,
  input wire logic limit_wr_i,
  input wire logic [ADDR_W-1:0] limit_data_i,
  // ram protection
  input wire logic boot_prot_en_i,
  input wire logic [ADDR_W-1:0] boot_ram_lo_i,
  input wire logic [ADDR_W-1:0] boot_ram_hi_i,
  input wire logic exec_in_boot_i,
  input wire logic sec_prot_en_i,
  input wire logic [ADDR_W-1:0] sec_ram_lo_i,
  input wire logic [ADDR_W-1:0] sec_ram_hi_i,
  input wire logic exec_in_secure_i,
  // to data memory
  output logic mem_valid_o,
  output logic mem_write_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [DATA_W-1:0] mem_wdata_o,
  output logic mem_denied_o,
  output logic [DATA_W-1:0] literal_o,
  output logic literal_valid_o,
  // pointer write-back
  output logic ptr_wb_o,
  output logic [REG_IDX_W-1:0] ptr_wb_idx_o,
  output logic [ADDR_W-1:0] ptr_wb_val_o,
  output logic [REG_IDX_W-1:0] result_reg_o,
  output logic result_to_reg_o,
  // traps and stack view
  output logic stack_trap_o,
  output logic [ADDR_W-1:0] stack_ptr_o,
  output logic [ADDR_W-1:0] stack_limit_o
);
  typedef struct packed {
    seq_state_t st;
    logic [ADDR_W-1:0] sp;
    logic [ADDR_W-1:0] limit;
    logic [15:0] hi_word;
    logic mem_valid;
    logic mem_write;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] wdata;
    logic denied;
    logic [DATA_W-1:0] lit;
    logic lit_valid;
    logic ptr_wb;
    logic [REG_IDX_W-1:0] wb_idx;
    logic [ADDR_W-1:0] wb_val;
    logic [REG_IDX_W-1:0] res_reg;
    logic res_to_reg;
    logic trap;
  } agu_state_t;

  agu_state_t q_r;
  agu_state_t q_nxt;
  logic [ADDR_W-1:0] ea;
  logic uses_sp;
  logic access;
  logic deny;
  logic [ADDR_W-1:0] ptr_cur;
  logic [ADDR_W-1:0] stepped;
  logic at_or_over;

  // the stack pointer is kept locally so pushes and pops see it directly
  assign ptr_cur = (ptr_idx_i == STACK_PTR_IDX) ? q_r.sp : ptr_val_i;
  assign stepped = ptr_cur + modifier_i;

  // effective address per mode
  always_comb
  begin
    ea = ADDR_RESET;
    case (mode_i)
      MODE_FILE_DIRECT:
      begin
        // move reaches the full space; others only the near 8 KiB
        ea = is_move_i ? move_addr_i : {3'h0, file_addr_i};
      end
      MODE_INDIRECT: ea = ptr_cur;
      MODE_POST_MOD: ea = ptr_cur;
      MODE_PRE_MOD: ea = stepped;
      MODE_REG_OFFSET: ea = ptr_cur + base_val_i;
      MODE_LIT_OFFSET: ea = ptr_cur + {6'h00, literal_i};
      default: ea = ADDR_RESET;
    endcase
  end

  assign access = req_i && (mode_i != MODE_REG_DIRECT) && (mode_i != MODE_LITERAL);
  assign uses_sp = access && (mode_i != MODE_FILE_DIRECT) && (ptr_idx_i == STACK_PTR_IDX);
  // strictly above limit traps, so a word pushed at the limit passes
  assign at_or_over = q_r.sp > q_r.limit;

  ram_guard ram_guard_i (
    .addr_i(ea),
    .access_i(access || (stack_op_i != STK_NONE)),
    .boot_prot_en_i(boot_prot_en_i),
    .boot_ram_lo_i(boot_ram_lo_i),
    .boot_ram_hi_i(boot_ram_hi_i),
    .exec_in_boot_i(exec_in_boot_i),
    .sec_prot_en_i(sec_prot_en_i),
    .sec_ram_lo_i(sec_ram_lo_i),
    .sec_ram_hi_i(sec_ram_hi_i),
    .exec_in_secure_i(exec_in_secure_i),
    .deny_o(deny)
  );

  // next-state logic; stack ops take priority over decoded data accesses
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.mem_valid = 1'b0;
    q_nxt.mem_write = 1'b0;
    q_nxt.ptr_wb = 1'b0;
    q_nxt.lit_valid = 1'b0;
    q_nxt.trap = 1'b0;
    q_nxt.denied = 1'b0;
    q_nxt.res_to_reg = 1'b0;
    if (limit_wr_i)
    begin
      q_nxt.limit = {limit_data_i[ADDR_W-1:1], 1'b0};
    end
    case (q_r.st)
      ST_IDLE:
      begin
        if (stack_op_i == STK_PUSH_CALL || stack_op_i == STK_PUSH_EXC)
        begin
          // low pc word first, upper word on the next cycle
          q_nxt.mem_valid = 1'b1;
          q_nxt.mem_write = 1'b1;
          q_nxt.mem_addr = q_r.sp;
          q_nxt.wdata = {pc_i[15:1], 1'b0};
          q_nxt.sp = q_r.sp + WORD_STEP;
          q_nxt.trap = at_or_over || (q_r.sp < UNDERFLOW_FLOOR);
          q_nxt.hi_word = (stack_op_i == STK_PUSH_EXC) ?
                          {status_low_byte_i, 1'b0, pc_i[22:16]} :
                          {9'h000, pc_i[22:16]};
          q_nxt.st = ST_PUSH_HI;
        end
        else if (stack_op_i == STK_POP)
        begin
          q_nxt.sp = q_r.sp - WORD_STEP;
          q_nxt.mem_valid = 1'b1;
          q_nxt.mem_addr = q_r.sp - WORD_STEP;
          q_nxt.trap = ((q_r.sp - WORD_STEP) < UNDERFLOW_FLOOR);
        end
        else if (req_i)
        begin
          q_nxt.mem_valid = access && !deny;
          q_nxt.denied = deny;
          q_nxt.mem_addr = ea;
          q_nxt.res_reg = (mode_i == MODE_FILE_DIRECT) ? FIRST_DEFAULT_WORKING_REG_IDX : ptr_idx_i;
          q_nxt.res_to_reg = (mode_i == MODE_FILE_DIRECT) && dest_is_default_working_reg_i && !is_mul_i;
          // base register operand passes register direct; literals go out
          q_nxt.lit = long_literal_i ? {6'h00, literal_i} :
                      {11'h000, literal_i[SHORT_LIT_W-1:0]};
          q_nxt.lit_valid = (mode_i == MODE_LITERAL);
          if (uses_sp)
          begin
            q_nxt.trap = (ea > q_r.limit) || (ea < UNDERFLOW_FLOOR);
          end
          if (mode_i == MODE_POST_MOD || mode_i == MODE_PRE_MOD)
          begin
            q_nxt.ptr_wb = 1'b1;
            q_nxt.wb_idx = ptr_idx_i;
            q_nxt.wb_val = stepped;
            if (ptr_idx_i == STACK_PTR_IDX)
            begin
              q_nxt.sp = {stepped[ADDR_W-1:1], 1'b0};
            end
          end
        end
      end
      ST_PUSH_HI:
      begin
        q_nxt.mem_valid = 1'b1;
        q_nxt.mem_write = 1'b1;
        q_nxt.mem_addr = q_r.sp;
        q_nxt.wdata = q_r.hi_word;
        q_nxt.sp = q_r.sp + WORD_STEP;
        q_nxt.trap = at_or_over;
        q_nxt.st = ST_DONE;
      end
      ST_DONE: q_nxt.st = ST_IDLE;
      default: q_nxt.st = ST_IDLE;
    endcase
  end

  // single register stage; the limit keeps its value through reset
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      q_r <= '0;
      q_r.st <= ST_IDLE;
      q_r.sp <= SP_RESET;
      q_r.limit <= q_nxt.limit;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign mem_valid_o = q_r.mem_valid;
  assign mem_write_o = q_r.mem_write;
  assign mem_addr_o = q_r.mem_addr;
  assign mem_wdata_o = q_r.wdata;
  assign mem_denied_o = q_r.denied;
  assign literal_o = q_r.lit;
  assign literal_valid_o = q_r.lit_valid;
  assign ptr_wb_o = q_r.ptr_wb;
  assign ptr_wb_idx_o = q_r.wb_idx;
  assign ptr_wb_val_o = q_r.wb_val;
  assign result_reg_o = q_r.res_reg;
  assign result_to_reg_o = q_r.res_to_reg;
  assign stack_trap_o = q_r.trap;
  assign stack_ptr_o = q_r.sp;
  assign stack_limit_o = q_r.limit;

  a_call_top_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (q_r.st == ST_IDLE && stack_op_i == STK_PUSH_CALL) |-> ##2 mem_wdata_o[15] == 1'b0)
    else $error("call push upper word has top bit set");
  a_push_steps_up: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (q_r.st == ST_IDLE && stack_op_i == STK_PUSH_CALL) |=>
    stack_ptr_o == $past(q_r.sp) + 16'h0002)
    else $error("push did not post-increment");
  a_pop_predec: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (q_r.st == ST_IDLE && stack_op_i == STK_POP) |=>
    mem_addr_o == stack_ptr_o && mem_valid_o)
    else $error("pop address not pre-decremented");
  a_limit_even: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    limit_wr_i |=> stack_limit_o == {$past(limit_data_i[15:1]), 1'b0})
    else $error("limit low bit not cleared");
  a_underflow_trap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (q_r.st == ST_IDLE && stack_op_i == STK_POP && q_r.sp < 16'h0802) |=> stack_trap_o)
    else $error("underflow missed");
  a_file_near: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (q_r.st == ST_IDLE && stack_op_i == STK_NONE && req_i && mode_i == MODE_FILE_DIRECT
     && !is_move_i && !deny) |=> mem_addr_o < 16'h2000)
    else $error("file address outside near space");
  a_boot_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (mem_denied_o) |-> !mem_valid_o)
    else $error("denied access reached memory");
  a_exc_status: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (q_r.st == ST_IDLE && stack_op_i == STK_PUSH_EXC) |-> ##2
    mem_wdata_o[15:8] == $past(status_low_byte_i, 2))
    else $error("status byte missing from exception push");
  // foreign code pointing into a protected range must be refused in the answer cycle
  a_boot_denied: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (q_r.st == ST_IDLE && stack_op_i == STK_NONE && req_i && mode_i == MODE_INDIRECT
     && ptr_idx_i != STACK_PTR_IDX && boot_prot_en_i && !exec_in_boot_i
     && ptr_val_i >= boot_ram_lo_i && ptr_val_i <= boot_ram_hi_i) |=>
    mem_denied_o && !mem_valid_o)
    else $error("boot secure ram reached from foreign code");
  a_sec_denied: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (q_r.st == ST_IDLE && stack_op_i == STK_NONE && req_i && mode_i == MODE_INDIRECT
     && ptr_idx_i != STACK_PTR_IDX && sec_prot_en_i && !exec_in_secure_i
     && ptr_val_i >= sec_ram_lo_i && ptr_val_i <= sec_ram_hi_i) |=>
    mem_denied_o && !mem_valid_o)
    else $error("secure segment ram reached from foreign code");
endmodule
`default_nettype wire

/* File: shared/agu_pkg.sv */
// constants and types for the address generator with stack checking
// assumes a 16-bit data space with byte addresses and word-aligned stack
package agu_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned FILE_ADDR_W = 13;
  localparam int unsigned SHORT_LIT_W = 5;
  localparam int unsigned LONG_LIT_W = 10;
  localparam int unsigned REG_IDX_W = 4;
  localparam logic [3:0] STACK_PTR_IDX = 4'hf;
  localparam logic [3:0] FIRST_DEFAULT_WORKING_REG_IDX = 4'h0;
  localparam logic [15:0] UNDERFLOW_FLOOR = 16'h0800;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0800;

  // addressing modes as delivered by the decoder
  typedef enum logic [2:0] {
    MODE_FILE_DIRECT = 3'h0,
    MODE_REG_DIRECT = 3'h1,
    MODE_INDIRECT = 3'h2,
    MODE_POST_MOD = 3'h3,
    MODE_PRE_MOD = 3'h4,
    MODE_REG_OFFSET = 3'h5,
    MODE_LIT_OFFSET = 3'h6,
    MODE_LITERAL = 3'h7
  } addr_mode_t;

  // stack operations
  typedef enum logic [1:0] {
    STK_NONE = 2'h0,
    STK_PUSH_CALL = 2'h1,
    STK_PUSH_EXC = 2'h2,
    STK_POP = 2'h3
  } stack_op_t;

  // access state, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PUSH_HI = 3'b010,
    ST_DONE = 3'b100
  } seq_state_t;
endpackage

/* File: core/ram_guard.sv */
// secure ram segment gate: decides whether an address may be touched
// assumes segment bounds and enables come from configuration, held stable
`timescale 1ns/1ps
`default_nettype none
module ram_guard
  import agu_pkg::*;
(
  // address under test
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic access_i,
  // boot secure segment
  input wire logic boot_prot_en_i,
  input wire logic [ADDR_W-1:0] boot_ram_lo_i,
  input wire logic [ADDR_W-1:0] boot_ram_hi_i,
  input wire logic exec_in_boot_i,
  // secure segment
  input wire logic sec_prot_en_i,
  input wire logic [ADDR_W-1:0] sec_ram_lo_i,
  input wire logic [ADDR_W-1:0] sec_ram_hi_i,
  input wire logic exec_in_secure_i,
  // verdict
  output logic deny_o
);
  logic in_boot;
  logic in_sec;

  // range checks are inclusive on both bounds
  assign in_boot = (addr_i >= boot_ram_lo_i) && (addr_i <= boot_ram_hi_i);
  assign in_sec = (addr_i >= sec_ram_lo_i) && (addr_i <= sec_ram_hi_i);
  // only the owning code segment may reach a protected segment
  assign deny_o = access_i && ((boot_prot_en_i && in_boot && !exec_in_boot_i) ||
                  (sec_prot_en_i && in_sec && !exec_in_secure_i));
endmodule
`default_nettype wire

/* File: tb/data_mem_model.sv */
// data memory model: keeps every word the block writes
// assumes writes are one-cycle pulses, settled by the falling edge
`timescale 1ns/1ps
`default_nettype none
module data_mem_model
  import agu_pkg::*;
(
  // clock
  input wire logic clk_i,
  // write side
  input wire logic valid_i,
  input wire logic write_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i
);
  logic [15:0] mem_r [logic [15:0]];

  // sample on the falling edge so a registered pulse is never raced
  always @(negedge clk_i)
  begin
    if (valid_i === 1'b1 && write_i === 1'b1)
      mem_r[addr_i] = wdata_i;
  end
endmodule
`default_nettype wire

/* File: tb/address_gen_stack_check_tb_top.sv */
// self-checking bench for the address generator with stack checks
// assumes agu_pkg and the data memory model are compiled first
`timescale 1ns/1ps
`default_nettype none
module address_gen_stack_check_tb_top
  import agu_pkg::*;
;
  // stimulus, all driven on the falling edge
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0, mv = 1'b0, mul = 1'b0, dw = 1'b0, llit = 1'b0, lwr = 1'b0;
  logic bpe = 1'b0, eb = 1'b0, spe = 1'b0, es = 1'b0;
  addr_mode_t mode = MODE_FILE_DIRECT;
  stack_op_t sop = STK_NONE;
  logic [12:0] fa = 13'h0000;
  logic [3:0] pidx = 4'h0;
  logic [9:0] lit = 10'h000;
  logic [7:0] slb = 8'h00;
  logic [22:0] pc = 23'h5abcdf;
  logic [15:0] ma = 16'h0000, pval = 16'h0000, bval = 16'h0000, ldat = 16'h0000;
  logic [15:0] blo = 16'h2000, bhi = 16'h20ff, slo = 16'h3000, shi = 16'h30ff;
  logic signed [15:0] modv = 16'hfffe;
  // observed
  logic mvld, mwr, mden, litv, wb, rtr, trap;
  logic [15:0] maddr, mwd, lito, wbv, sp, lim;
  logic [3:0] wbi, rr;
  int err_count = 0;
  int compares = 0;

  always #4 clk = ~clk;

  address_gen_stack_check address_gen_stack_check_i (
    .ref_clk_i(clk), .rst_n_i(rst_n), .req_i(req), .mode_i(mode), .is_move_i(mv),
    .is_mul_i(mul), .dest_is_default_working_reg_i(dw), .file_addr_i(fa), .move_addr_i(ma),
    .ptr_idx_i(pidx), .ptr_val_i(pval), .base_val_i(bval), .literal_i(lit),
    .long_literal_i(llit), .modifier_i(modv), .stack_op_i(sop), .pc_i(pc),
    .status_low_byte_i(slb), .limit_wr_i(lwr), .limit_data_i(ldat),
    .boot_prot_en_i(bpe), .boot_ram_lo_i(blo), .boot_ram_hi_i(bhi), .exec_in_boot_i(eb),
    .sec_prot_en_i(spe), .sec_ram_lo_i(slo), .sec_ram_hi_i(shi), .exec_in_secure_i(es),
    .mem_valid_o(mvld), .mem_write_o(mwr), .mem_addr_o(maddr), .mem_wdata_o(mwd),
    .mem_denied_o(mden), .literal_o(lito), .literal_valid_o(litv), .ptr_wb_o(wb),
    .ptr_wb_idx_o(wbi), .ptr_wb_val_o(wbv), .result_reg_o(rr), .result_to_reg_o(rtr),
    .stack_trap_o(trap), .stack_ptr_o(sp), .stack_limit_o(lim));

  data_mem_model data_mem_model_i (.clk_i(clk), .valid_i(mvld), .write_i(mwr),
    .addr_i(maddr), .wdata_i(mwd));

  task automatic chk(input string n, input logic [22:0] s, input logic [22:0] e);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic complete_run;
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one stack request, held for a single taking edge
  task automatic stk(input stack_op_t op);
    @(negedge clk);
    sop = op;
    @(negedge clk);
    sop = STK_NONE;
  endtask

  // tr and th are the expected trap pulses of the low and the high word
  task automatic push(input stack_op_t op, input logic [7:0] st, input logic tr,
    input logic th);
    logic [15:0] a;
    logic [15:0] hi;
    a = sp;
    slb = st;
    hi = (op == STK_PUSH_CALL) ? {9'h000, pc[22:16]} : {st, 1'b0, pc[22:16]};
    stk(op);
    chk("push lo addr", maddr, a);
    chk("push write", mwr, 1'b1);
    chk("push trap", trap, tr);
    @(negedge clk);
    chk("push hi addr", maddr, a + 16'h0002);
    chk("push hi trap", trap, th);
    @(negedge clk);
    chk("push sp", sp, a + 16'h0004);
    // a push whose low word traps is still written to memory, but its words are not judged
    if (!tr)
    begin
      chk("lo word", data_mem_model_i.mem_r[a], {pc[15:1], 1'b0});
      chk("hi word", data_mem_model_i.mem_r[a + 16'h0002], hi);
    end
  endtask

  task automatic pop(input logic tr);
    logic [15:0] a;
    a = sp - 16'h0002;
    stk(STK_POP);
    chk("pop addr", maddr, a);
    chk("pop sp", sp, a);
    chk("pop write", mwr, 1'b0);
    chk("pop trap", trap, tr);
  endtask

  // one data request; outputs are judged in the answer cycle
  task automatic acc(input addr_mode_t m, input logic v, input logic dn,
    input logic [15:0] ea, input logic wk, input logic [15:0] wv);
    @(negedge clk);
    mode = m;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    chk("mem valid", mvld, v);
    chk("denied", mden, dn);
    if (v)
      chk("ea", maddr, ea);
    chk("ptr wb", wb, wk);
    if (wk)
      chk("wb val", {wbi, wbv}, {pidx, wv});
  endtask

  task automatic wr_limit(input logic [15:0] d);
    @(negedge clk);
    lwr = 1'b1;
    ldat = d;
    @(negedge clk);
    lwr = 1'b0;
  endtask

  task automatic t_reset_limit;
    chk("sp reset", sp, SP_RESET);
    chk("trap reset", trap, 1'b0);
    wr_limit(16'h1fff);
    chk("limit lsb", lim, 16'h1ffe);
  endtask

  task automatic t_push_pop;
    push(STK_PUSH_CALL, 8'h00, 1'b0, 1'b0);
    push(STK_PUSH_EXC, 8'hc3, 1'b0, 1'b0);
    repeat (4) pop(1'b0);
    pop(1'b1);
  endtask

  // second reset mid-run: the limit must survive it
  task automatic t_limit_trap;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    pc = 23'h2468ac;
    chk("sp rereset", sp, SP_RESET);
    chk("limit kept", lim, 16'h1ffe);
    wr_limit(16'h0804);
    push(STK_PUSH_CALL, 8'h00, 1'b0, 1'b0);
    // low word at the limit passes, the word after it traps
    push(STK_PUSH_CALL, 8'h00, 1'b0, 1'b1);
    push(STK_PUSH_CALL, 8'h00, 1'b1, 1'b1);
  endtask

  task automatic t_sp_ea;
    repeat (2) @(negedge clk);
    pidx = STACK_PTR_IDX;
    pval = 16'h080c;
    acc(MODE_INDIRECT, 1'b1, 1'b0, 16'h080c, 1'b0, 16'h0000);
    chk("sp ea trap", trap, 1'b1);
    pidx = 4'h1;
    acc(MODE_INDIRECT, 1'b1, 1'b0, 16'h080c, 1'b0, 16'h0000);
    chk("other ea trap", trap, 1'b0);
  endtask

  task automatic t_modes;
    pidx = 4'h3;
    pval = 16'h1234;
    bval = 16'h0100;
    lit = 10'h2a5;
    fa = 13'h1fff;
    dw = 1'b1;
    acc(MODE_FILE_DIRECT, 1'b1, 1'b0, 16'h1fff, 1'b0, 16'h0000);
    chk("result reg", {rtr, rr}, {1'b1, FIRST_DEFAULT_WORKING_REG_IDX});
    mul = 1'b1;
    acc(MODE_FILE_DIRECT, 1'b1, 1'b0, 16'h1fff, 1'b0, 16'h0000);
    chk("mul result", rtr, 1'b0);
    mul = 1'b0;
    mv = 1'b1;
    ma = 16'hf00e;
    acc(MODE_FILE_DIRECT, 1'b1, 1'b0, 16'hf00e, 1'b0, 16'h0000);
    mv = 1'b0;
    acc(MODE_INDIRECT, 1'b1, 1'b0, 16'h1234, 1'b0, 16'h0000);
    acc(MODE_POST_MOD, 1'b1, 1'b0, 16'h1234, 1'b1, 16'h1232);
    acc(MODE_PRE_MOD, 1'b1, 1'b0, 16'h1232, 1'b1, 16'h1232);
    acc(MODE_REG_OFFSET, 1'b1, 1'b0, 16'h1334, 1'b0, 16'h0000);
    acc(MODE_LIT_OFFSET, 1'b1, 1'b0, 16'h14d9, 1'b0, 16'h0000);
    acc(MODE_REG_DIRECT, 1'b0, 1'b0, 16'h0000, 1'b0, 16'h0000);
    llit = 1'b1;
    acc(MODE_LITERAL, 1'b0, 1'b0, 16'h0000, 1'b0, 16'h0000);
    chk("long literal", {litv, lito}, {1'b1, 16'h02a5});
    llit = 1'b0;
    acc(MODE_LITERAL, 1'b0, 1'b0, 16'h0000, 1'b0, 16'h0000);
    chk("short literal", {litv, lito}, {1'b1, 16'h0005});
  endtask

  task automatic t_protect;
    pval = 16'h2010;
    bpe = 1'b1;
    acc(MODE_INDIRECT, 1'b0, 1'b1, 16'h2010, 1'b0, 16'h0000);
    eb = 1'b1;
    acc(MODE_INDIRECT, 1'b1, 1'b0, 16'h2010, 1'b0, 16'h0000);
    spe = 1'b1;
    pval = 16'h30ff;
    acc(MODE_INDIRECT, 1'b0, 1'b1, 16'h30ff, 1'b0, 16'h0000);
    es = 1'b1;
    acc(MODE_INDIRECT, 1'b1, 1'b0, 16'h30ff, 1'b0, 16'h0000);
  endtask

  // main sequence
  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_reset_limit();
    t_push_pop();
    t_limit_trap();
    t_sp_ea();
    t_modes();
    t_protect();
    complete_run();
  end

  // watchdog: tests need about 80 cycles, allow some 25 times that
  initial
  begin
    #16000;
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
